// ### core/fifo_thr_consts.vh
// fifo threshold block constants: offsets, field positions, reset values
// included by the threshold control and compare modules
`ifndef FIFO_THR_CONSTS_VH
`define FIFO_THR_CONSTS_VH
`define OFS_HALT_RESUME 3'h6
`define OFS_TRIGGER 3'h7
`define OFS_READY_SUMMARY 3'h7
`define RST_HALT_RESUME 8'h00
`define RST_TRIGGER 8'h00
`define RST_READY_SUMMARY 8'hff
`define HI_NIB_MSB 7
`define HI_NIB_LSB 4
`define LO_NIB_MSB 3
`define LO_NIB_LSB 0
`define LCR_DLAB_BIT 7
`define MCR_TLR_EN_BIT 6
`define MCR_RDY_MODE_BIT 4
`define MCR_RDY_EN_BIT 2
`define ASR_RDY_DIS_BIT 0
`define LEVEL_SCALE 2
`endif

// ### core/thr_compare.v
// one channel's threshold compares: halt/resume hysteresis and triggers
// assumes fill and free counts are synchronous to clk
`timescale 1ns/100ps
`include "fifo_thr_consts.vh"
module thr_compare #(
    parameter CW = 7
) (
    input wire clk,
    input wire reset_n,
    input wire [7:0] haltResume,
    input wire [7:0] trigger,
    input wire [CW-1:0] legacyHalt,
    input wire [CW-1:0] legacyResume,
    input wire [CW-1:0] legacyRxTrig,
    input wire [CW-1:0] legacyTxTrig,
    input wire [CW-1:0] rxCount,
    input wire [CW-1:0] txFree,
    output reg flowHalted,
    output reg rxReady,
    output reg txReady
);
    // ------------------------------------------------------------
    // level selection
    // ------------------------------------------------------------
    function [CW-1:0] pickLevel;
        input [3:0] field;
        input [CW-1:0] legacy;
        begin
            if (field == 4'h0)
                pickLevel = legacy;
            else
                pickLevel = {{(CW-6){1'b0}}, field, 2'b00};
        end
    endfunction

    wire [CW-1:0] resumeLvl;
    wire [CW-1:0] haltLvl;
    wire [CW-1:0] rxTrigLvl;
    wire [CW-1:0] txTrigLvl;
    // zero field falls back to legacy, else field times four
    assign resumeLvl = pickLevel(haltResume[7:4], legacyResume);
    assign haltLvl = pickLevel(haltResume[3:0], legacyHalt);
    assign rxTrigLvl = pickLevel(trigger[7:4], legacyRxTrig);
    assign txTrigLvl = pickLevel(trigger[3:0], legacyTxTrig);

    // ------------------------------------------------------------
    // compares, every clock
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            flowHalted <= 1'b0;
            rxReady <= 1'b0;
            txReady <= 1'b0;
        end
        else
        begin
            if (rxCount >= haltLvl)
                flowHalted <= 1'b1;
            else if (rxCount <= resumeLvl)
                flowHalted <= 1'b0;
            rxReady <= (rxCount >= rxTrigLvl);
            txReady <= (txFree >= txTrigLvl);
        end
    end
endmodule // thr_compare

// ### core/uart_fifo_threshold_control.v
// dual-channel fifo threshold control with its register access
// assumes a synchronous parallel register port and external fifo counters
//
// Function
// - at or below four times the resume field, flow resumes (rts on or xon sent).
// - at or above four times the halt field, flow halts (rts off or xoff sent).
// - a zero resume field takes the legacy resume level instead.
// - a zero halt field takes the legacy halt level instead.
// - receive ready rises when the receive count reaches four times its field.
// - a zero receive trigger field uses the level chosen by fifo control bits 7:6.
// - transmit ready rises when free space reaches four times its field.
// - a zero transmit trigger field uses the level chosen by fifo control bits 5:4.
// - level registers are reached only with dlab clear and modem control bit 6 set.
// - the ready summary reads only with dlab, mcr4, disable clear, mcr2 set, a select low.
// - the ready summary gives rx states high, tx states low, and resets to all ones.
// - the auxiliary ready-disable bit blocks the ready summary.
`timescale 1ns/100ps
`include "fifo_thr_consts.vh"
module uart_fifo_threshold_control #(
    parameter CW = 7
) (
    input wire clk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    input wire [1:0] channel_selects_n,
    input wire [7:0] line_control_reg_a,
    input wire [7:0] line_control_reg_b,
    input wire [7:0] modem_control_reg_a,
    input wire [7:0] modem_control_reg_b,
    input wire [7:0] auxiliary_settings_reg_a,
    input wire [7:0] auxiliary_settings_reg_b,
    input wire [1:0] autoRtsEn,
    input wire [1:0] autoSwFlowEn,
    input wire [2*CW-1:0] legacyHalt,
    input wire [2*CW-1:0] legacyResume,
    input wire [2*CW-1:0] legacyRxTrig,
    input wire [2*CW-1:0] legacyTxTrig,
    input wire [2*CW-1:0] rxCount,
    input wire [2*CW-1:0] txFree,
    input wire [3:0] rxFifoState,
    input wire [3:0] txFifoState,
    output reg [7:0] rdData,
    output reg rdValid,
    output reg [1:0] rts_n,
    output reg [1:0] sendXon,
    output reg [1:0] sendXoff,
    output reg [1:0] rxReadyIrq,
    output reg [1:0] txReadyIrq
);
    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    function levelAccess;
        input [7:0] line_control_reg;
        input [7:0] modem_control_reg;
        begin
            levelAccess = !line_control_reg[`LCR_DLAB_BIT] && modem_control_reg[`MCR_TLR_EN_BIT];
        end
    endfunction

    function readyAccess;
        input [7:0] line_control_reg;
        input [7:0] modem_control_reg;
        input [7:0] auxiliary_settings_reg;
        begin
            readyAccess = !line_control_reg[`LCR_DLAB_BIT] && !modem_control_reg[`MCR_RDY_MODE_BIT]
                && modem_control_reg[`MCR_RDY_EN_BIT] && !auxiliary_settings_reg[`ASR_RDY_DIS_BIT];
        end
    endfunction

    wire [7:0] line_control_reg [0:1];
    wire [7:0] modem_control_reg [0:1];
    wire [7:0] auxiliary_settings_reg [0:1];
    assign line_control_reg[0] = line_control_reg_a;
    assign line_control_reg[1] = line_control_reg_b;
    assign modem_control_reg[0] = modem_control_reg_a;
    assign modem_control_reg[1] = modem_control_reg_b;
    assign auxiliary_settings_reg[0] = auxiliary_settings_reg_a;
    assign auxiliary_settings_reg[1] = auxiliary_settings_reg_b;

    reg [7:0] flow_halt_resume_levels [0:1];
    reg [7:0] fifo_trigger_levels [0:1];
    reg [7:0] fifo_ready_summary;
    wire [1:0] flowHalted;
    wire [1:0] rxReady;
    wire [1:0] txReady;
    reg [1:0] haltedLast;

    // ------------------------------------------------------------
    // per-channel registers and compares
    // ------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1)
        begin : chan
            wire sel;
            wire lvlOk;
            assign sel = !channel_selects_n[ch];
            assign lvlOk = levelAccess(line_control_reg[ch], modem_control_reg[ch]);

            // register writes, gated by access mode
            always @(posedge clk)
            begin
                if (!reset_n)
                begin
                    flow_halt_resume_levels[ch] <= `RST_HALT_RESUME;
                    fifo_trigger_levels[ch] <= `RST_TRIGGER;
                end
                else if (wrStrobe && sel && lvlOk)
                begin
                    if (addr == `OFS_HALT_RESUME)
                        flow_halt_resume_levels[ch] <= wrData;
                    if (addr == `OFS_TRIGGER)
                        fifo_trigger_levels[ch] <= wrData;
                end
            end

            thr_compare #(
                .CW(CW)
            ) u_cmp (
                .clk(clk),
                .reset_n(reset_n),
                .haltResume(flow_halt_resume_levels[ch]),
                .trigger(fifo_trigger_levels[ch]),
                .legacyHalt(legacyHalt[ch*CW +: CW]),
                .legacyResume(legacyResume[ch*CW +: CW]),
                .legacyRxTrig(legacyRxTrig[ch*CW +: CW]),
                .legacyTxTrig(legacyTxTrig[ch*CW +: CW]),
                .rxCount(rxCount[ch*CW +: CW]),
                .txFree(txFree[ch*CW +: CW]),
                .flowHalted(flowHalted[ch]),
                .rxReady(rxReady[ch]),
                .txReady(txReady[ch])
            );

            // flow outputs: rts level, xon/xoff one-cycle requests on change
            always @(posedge clk)
            begin
                if (!reset_n)
                begin
                    rts_n[ch] <= 1'b0;
                    sendXon[ch] <= 1'b0;
                    sendXoff[ch] <= 1'b0;
                    haltedLast[ch] <= 1'b0;
                    rxReadyIrq[ch] <= 1'b0;
                    txReadyIrq[ch] <= 1'b0;
                end
                else
                begin
                    haltedLast[ch] <= flowHalted[ch];
                    rts_n[ch] <= autoRtsEn[ch] & flowHalted[ch];
                    sendXoff[ch] <= autoSwFlowEn[ch] & flowHalted[ch]
                        & ~haltedLast[ch];
                    sendXon[ch] <= autoSwFlowEn[ch] & ~flowHalted[ch]
                        & haltedLast[ch];
                    rxReadyIrq[ch] <= rxReady[ch];
                    txReadyIrq[ch] <= txReady[ch];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // ready summary, sampled each clock
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!reset_n)
            fifo_ready_summary <= `RST_READY_SUMMARY;
        else
            fifo_ready_summary <= {rxFifoState, txFifoState};
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    reg [7:0] next_rdData;
    reg next_rdValid;
    reg [0:0] rch;
    always @*
    begin
        next_rdData = 8'h00;
        next_rdValid = 1'b0;
        rch = channel_selects_n[0] ? 1'b1 : 1'b0;
        if (rdStrobe && (channel_selects_n != 2'b11))
        begin
            if (addr == `OFS_READY_SUMMARY && readyAccess(line_control_reg[rch], modem_control_reg[rch], auxiliary_settings_reg[rch]))
            begin
                next_rdData = fifo_ready_summary;
                next_rdValid = 1'b1;
            end
            else if (levelAccess(line_control_reg[rch], modem_control_reg[rch]))
            begin
                if (addr == `OFS_HALT_RESUME)
                begin
                    next_rdData = flow_halt_resume_levels[rch];
                    next_rdValid = 1'b1;
                end
                else if (addr == `OFS_TRIGGER)
                begin
                    next_rdData = fifo_trigger_levels[rch];
                    next_rdValid = 1'b1;
                end
            end
        end
    end

    // registered read answer
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            rdData <= 8'h00;
            rdValid <= 1'b0;
        end
        else
        begin
            rdData <= next_rdData;
            rdValid <= next_rdValid;
        end
    end
endmodule // uart_fifo_threshold_control

// ### bench/uart_thr_props.sv
// checker: register answers, flow levels and tx ready of channel a
// assumes only the top module ports; bound after the module
`timescale 1ns/100ps
module uart_thr_props #(
    parameter CW = 7
) (
    input wire clk,
    input wire reset_n,
    input wire [2:0] addr,
    input wire [7:0] wrData,
    input wire wrStrobe,
    input wire rdStrobe,
    input wire [1:0] channel_selects_n,
    input wire [7:0] line_control_reg_a,
    input wire [7:0] modem_control_reg_a,
    input wire [1:0] autoRtsEn,
    input wire [2*CW-1:0] legacyHalt,
    input wire [2*CW-1:0] legacyResume,
    input wire [2*CW-1:0] legacyTxTrig,
    input wire [2*CW-1:0] rxCount,
    input wire [2*CW-1:0] txFree,
    input wire [7:0] rdData,
    input wire rdValid,
    input wire [1:0] rts_n,
    input wire [1:0] sendXoff,
    input wire [1:0] txReadyIrq
);
    reg [7:0] hr;
    reg [7:0] tr;
    // level access for channel a and the thresholds it selects
    wire lvlOk = !line_control_reg_a[7] && modem_control_reg_a[6] && !channel_selects_n[0];
    wire [CW-1:0] rxA = rxCount[CW-1:0];
    wire [CW-1:0] txA = txFree[CW-1:0];
    wire [CW-1:0] hLvl = (hr[3:0] != 4'h0) ? {hr[3:0], 2'b00} : legacyHalt[CW-1:0];
    wire [CW-1:0] rLvl = (hr[7:4] != 4'h0) ? {hr[7:4], 2'b00} : legacyResume[CW-1:0];
    wire [CW-1:0] tLvl = (tr[3:0] != 4'h0) ? {tr[3:0], 2'b00} : legacyTxTrig[CW-1:0];
    // mirror of the channel a level registers
    always @(posedge clk)
    begin
        if (!reset_n)
        begin
            hr <= 8'h00;
            tr <= 8'h00;
        end
        else if (wrStrobe && lvlOk && addr == 3'h6)
            hr <= wrData;
        else if (wrStrobe && lvlOk && addr == 3'h7)
            tr <= wrData;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence sHalt; autoRtsEn[0] && rxA >= hLvl; endsequence
    sequence sRes; autoRtsEn[0] && rxA <= rLvl && rxA < hLvl; endsequence
    sequence sTx; txA >= tLvl; endsequence
    a_read_answer: assert property (rdStrobe && lvlOk && addr == 3'h6 |=> rdValid && rdData == hr)
        else $error("level register read wrong");
    a_refused_read: assert property (rdStrobe && line_control_reg_a[7] && channel_selects_n == 2'b10 |=> !rdValid)
        else $error("refused read answered");
    a_stray_valid: assert property (!rdStrobe |=> !rdValid)
        else $error("read data without read");
    a_halt_rts: assert property (sHalt ##1 sHalt |=> rts_n[0])
        else $error("flow not halted");
    a_resume_rts: assert property (sRes ##1 sRes |=> !rts_n[0])
        else $error("flow not resumed");
    a_xoff_pulse: assert property (sendXoff[0] |=> !sendXoff[0])
        else $error("xoff request too long");
    a_tx_ready: assert property (sTx ##1 sTx |=> txReadyIrq[0])
        else $error("tx ready missing");
    a_tx_idle: assert property ((txA < tLvl) [*2] |=> !txReadyIrq[0])
        else $error("tx ready too early");
endmodule // uart_thr_props
bind uart_fifo_threshold_control uart_thr_props #(.CW(CW)) uart_thr_props_inst (.clk, .reset_n,
    .addr, .wrData, .wrStrobe, .rdStrobe, .channel_selects_n, .line_control_reg_a,
    .modem_control_reg_a, .autoRtsEn, .legacyHalt, .legacyResume, .legacyTxTrig, .rxCount,
    .txFree, .rdData, .rdValid, .rts_n, .sendXoff, .txReadyIrq);

// ### bench/host_bus_model.sv
// host side of the register port: one-cycle read or write strobes
// assumes the block samples its register port on the rising edge
`timescale 1ns/100ps
module host_bus_model (
    input wire clk,
    output reg [2:0] addr,
    output reg [7:0] wrData,
    output reg wrStrobe,
    output reg rdStrobe,
    output reg [1:0] channel_selects_n
);
    initial {addr, wrData, wrStrobe, rdStrobe, channel_selects_n} = 15'h0003;
    // one bus cycle, held across exactly one rising edge
    task cycle(input [2:0] a, input [7:0] d, input w, input [1:0] cs);
    begin
        @(negedge clk);
        addr = a;
        wrData = d;
        channel_selects_n = cs;
        wrStrobe = w;
        rdStrobe = !w;
        @(negedge clk);
        {wrStrobe, rdStrobe, channel_selects_n} = 4'h3;
        addr = ~a; // released lines do not keep old values
        wrData = ~d;
    end
    endtask
endmodule // host_bus_model

// ### bench/tb.sv
// self-checking bench: register access, flow thresholds, trigger levels
// assumes a 50 MHz clock and a synchronous active-low reset
`timescale 1ns/100ps
module tb;
    reg clk = 1'b0;
    reg reset_n = 1'b0;
    reg [7:0] line_control_reg = 8'h00, modem_control_reg = 8'h40, auxiliary_settings_reg = 8'h00;
    reg [1:0] rtsEn = 2'h0, swEn = 2'h0;
    reg [13:0] lHalt = {2{7'd20}}, lRes = {2{7'd4}}, lRx = {2{7'd24}}, lTx = {2{7'd36}};
    reg [13:0] rx = 14'h0, tx = 14'h0;
    reg [3:0] rxSt = 4'h0, txSt = 4'h0, rf, tf;
    wire [2:0] addr;
    wire [7:0] wrData, rdData;
    wire wrS, rdS, rdValid;
    wire [1:0] sel, rtsN, xon, xoff, rxIrq, txIrq;
    reg [7:0] expQ[$];
    integer failures = 0, cmpCount = 0, cycles = 0, xonCnt = 0, xoffCnt = 0, i, rl, tl;
    always #10 clk = ~clk;
    host_bus_model host_bus_model_inst (.clk(clk), .addr(addr), .wrData(wrData),
        .wrStrobe(wrS), .rdStrobe(rdS), .channel_selects_n(sel));
    uart_fifo_threshold_control #(.CW(7)) uart_fifo_threshold_control_inst (.clk(clk),
        .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrStrobe(wrS), .rdStrobe(rdS),
        .channel_selects_n(sel), .line_control_reg_a(line_control_reg), .line_control_reg_b(line_control_reg),
        .modem_control_reg_a(modem_control_reg), .modem_control_reg_b(modem_control_reg), .auxiliary_settings_reg_a(auxiliary_settings_reg),
        .auxiliary_settings_reg_b(auxiliary_settings_reg), .autoRtsEn(rtsEn), .autoSwFlowEn(swEn),
        .legacyHalt(lHalt), .legacyResume(lRes), .legacyRxTrig(lRx), .legacyTxTrig(lTx),
        .rxCount(rx), .txFree(tx), .rxFifoState(rxSt), .txFifoState(txSt), .rdData(rdData),
        .rdValid(rdValid), .rts_n(rtsN), .sendXon(xon), .sendXoff(xoff), .rxReadyIrq(rxIrq),
        .txReadyIrq(txIrq));
    task chk(input [7:0] got, input [7:0] exp);
    begin
        cmpCount = cmpCount + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task print_verdict;
    begin
        $display("failures=%0d comparisons=%0d", failures, cmpCount);
        if (failures == 0 && cmpCount > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        host_bus_model_inst.cycle(a, d, 1'b1, 2'b10);
    endtask
    // a read notes its expected byte only when it should be answered
    task rd(input [2:0] a, input [1:0] cs, input [7:0] e, input ok);
    begin
        if (ok)
            expQ.push_back(e);
        host_bus_model_inst.cycle(a, 8'h00, 1'b0, cs);
    end
    endtask
    task lvl(input [13:0] r, input [13:0] t);
    begin
        @(negedge clk);
        rx = r;
        tx = t;
        repeat (3) @(negedge clk);
    end
    endtask
    // read answers, flow pulses and the cycle limit
    always @(negedge clk)
    begin
        cycles = cycles + 1;
        xonCnt = xonCnt + xon[0];
        xoffCnt = xoffCnt + xoff[0];
        if (rdValid !== 1'b0)
            chk(rdData, expQ.size() ? expQ.pop_front() : ~rdData);
        if (cycles == 4000)
        begin
            failures = failures + 1;
            print_verdict;
        end
    end
    initial
    begin
        void'($urandom(43873));
        repeat (2) @(negedge clk);
        reset_n = 1'b1;
        rd(3'h6, 2'b10, 8'h00, 1);
        rd(3'h7, 2'b10, 8'h00, 1);
        wr(3'h6, 8'h28);
        rtsEn = 2'h1;
        lvl(31, 0); chk(rtsN, 2'h0);
        lvl(32, 0); chk(rtsN, 2'h1);
        lvl(9, 0); chk(rtsN, 2'h1);
        lvl(8, 0); chk(rtsN, 2'h0);
        rtsEn = 2'h0; swEn = 2'h1; xonCnt = 0; xoffCnt = 0;
        lvl(40, 0); lvl(8, 0);
        chk(xoffCnt, 1);
        chk(xonCnt, 1);
        swEn = 2'h0; rtsEn = 2'h1; wr(3'h6, 8'h00);
        lvl(20, 0); chk(rtsN, 2'h1);
        lvl(5, 0); chk(rtsN, 2'h1);
        lvl(4, 0); chk(rtsN, 2'h0);
        for (i = 0; i < 2; i++)
        begin
            rf = i ? 4'h0 : 4'h1 + $urandom % 15;
            tf = i ? 4'h0 : 4'h1 + $urandom % 15;
            wr(3'h7, {rf, tf});
            rl = rf ? rf * 4 : 24;
            tl = tf ? tf * 4 : 36;
            lvl(rl - 1, tl - 1); chk({rxIrq, txIrq}, 4'h0);
            lvl(rl, tl); chk({rxIrq, txIrq}, 4'h5);
            rd(3'h7, 2'b10, {rf, tf}, 1);
        end
        line_control_reg = 8'h80; wr(3'h6, 8'h5a); rd(3'h6, 2'b10, 8'h00, 0);
        line_control_reg = 8'h00; modem_control_reg = 8'h00; rd(3'h6, 2'b10, 8'h00, 0);
        modem_control_reg = 8'h40; rd(3'h6, 2'b10, 8'h00, 1);
        rxSt = $urandom | 1; txSt = $urandom; modem_control_reg = 8'h44;
        rd(3'h7, 2'b01, {rxSt, txSt}, 1);
        rd(3'h7, 2'b11, 8'h00, 0);
        auxiliary_settings_reg = 8'h01; rd(3'h7, 2'b10, 8'h00, 1);
        auxiliary_settings_reg = 8'h00; modem_control_reg = 8'h54; rd(3'h7, 2'b10, 8'h00, 1);
        repeat (3) @(negedge clk);
        chk(expQ.size(), 0);
        print_verdict;
    end
endmodule // tb
